//--- design/cisa_pkg.sv
// What this block does
// - Short stack adjust: imm<<3 signed, add sp
// - Prefixed stack adjust: 16-bit signed imm
// - No overflow trap; wrap, then sign-extend
// - Short stack-relative: imm<<2 zero-extended to dest
// - Prefixed stack-relative: signed 16-bit to dest
// - Three-register word add into third field
// - Two-register AND written back to first
// - Decode macro word and its five fields
// - Selector picks macro; parameters substituted
// - Hold program counter until expansion ends
// - Undefined macro raises reserved instruction
// - Macro count and interrupt masking fixed
package cisa_pkg;
    // ------------------------------------------------------------
    // Opcodes and widths
    // ------------------------------------------------------------
    localparam int          XLEN             = 64;
    localparam logic [4:0]  OP_PREFIX        = 5'h1e;
    localparam logic [4:0]  OP_STACK_GROUP   = 5'h0c;
    localparam logic [2:0]  STACK_ADJUST_SUB = 3'h3;
    localparam logic [4:0]  OP_SP_REL_ADD    = 5'h00;
    localparam logic [4:0]  OP_THREE_REG     = 5'h1c;
    localparam logic [1:0]  FN_ADD_WORD      = 2'h1;
    localparam logic [4:0]  OP_TWO_REG       = 5'h1d;
    localparam logic [4:0]  FN_AND           = 5'h0c;
    localparam logic [2:0]  PREFIX_ZERO_FLD  = 3'h0;
    localparam logic [4:0]  STACK_PTR_REG    = 5'h1d;
    // Selector values that this implementation defines
    localparam logic [7:0]  MACRO_DEFINED    = 8'h03;
    localparam logic [1:0]  MACRO_STEPS      = 2'h2;
    // Interrupts held off during expansion (fixed choice)
    localparam logic        MACRO_MASKS_IRQ  = 1'b1;

    typedef enum logic [2:0] {
        CISA_NONE, CISA_ADJ, CISA_SPREL, CISA_ADDW, CISA_AND, CISA_MACRO, CISA_RSVD
    } cisa_kind_t;
endpackage

//--- design/cisa_macro_rom.sv
`timescale 1ns/10ps
// Macro templates; read data registered
module cisa_macro_rom
    import cisa_pkg::*;
(
    input  wire logic        clock,
    input  wire logic [2:0]  sel,
    input  wire logic [1:0]  step,
    output logic      [31:0] tmpl
);
    // ------------------------------------------------------------
    // Template table: fields filled by parameters later
    // ------------------------------------------------------------
    logic [31:0] rom_word;
    always_comb begin
        case ({sel, step})
            5'h00:   rom_word = 32'h24000000; // add imm: rt=p1, rs=p2, imm=p3
            5'h01:   rom_word = 32'h00000021; // reg add: rd=p0, rs=p2, rt=p4
            5'h04:   rom_word = 32'h00000024; // and: rd=p0, rs=p2, rt=p1
            5'h05:   rom_word = 32'h00000000; // no-op
            default: rom_word = 32'h00000000;
        endcase
    end
    always_ff @(posedge clock) begin
        tmpl <= rom_word;
    end
endmodule

//--- design/cisa_exec.sv
`timescale 1ns/10ps
module cisa_exec
    import cisa_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic            insn_valid,
    input  wire logic [31:0]     insn,
    input  wire logic            insn_is_ext,
    input  wire logic [XLEN-1:0] rs_data,
    input  wire logic [XLEN-1:0] rt_data,
    output logic      [4:0]      rs_addr,
    output logic      [4:0]      rt_addr,
    output logic                 wr_en,
    output logic      [4:0]      wr_addr,
    output logic      [XLEN-1:0] wr_data,
    output logic                 pc_hold,
    output logic                 irq_mask,
    output logic                 macro_word_valid,
    output logic      [31:0]     macro_word,
    output logic                 rsvd_insn
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Field to register number
    function automatic logic [4:0] xlat(input logic [2:0] f);
        xlat = (f < 3'h2) ? {2'b10, 2'b00, f[0]} : {2'b00, f};
    endfunction
    // Keep low word, sign-extend; no overflow check
    function automatic logic [XLEN-1:0] sext32(input logic [XLEN-1:0] v);
        sext32 = {{(XLEN-32){v[31]}}, v[31:0]};
    endfunction

    logic [15:0] op;
    logic [4:0]  major;
    logic [15:0] ext_imm;
    assign op      = insn[15:0];
    assign major   = op[15:11];
    assign ext_imm = {insn[20:16], insn[26:21], op[4:0]};

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    cisa_kind_t  kind;
    logic [XLEN-1:0] imm;
    always_comb begin
        kind    = CISA_NONE;
        imm     = '0;
        rs_addr = STACK_PTR_REG;
        rt_addr = 5'h00;
        wr_addr = STACK_PTR_REG;
        if (insn_valid) begin
            if (insn_is_ext && insn[31:27] != OP_PREFIX) begin
                kind = CISA_NONE;
            end else if (insn_is_ext && major == OP_THREE_REG) begin
                kind = MACRO_DEFINED[insn[26:24]] ? CISA_MACRO : CISA_RSVD;
            end else if (major == OP_STACK_GROUP && op[10:8] == STACK_ADJUST_SUB) begin
                if (insn_is_ext) begin
                    kind = (op[7:5] == PREFIX_ZERO_FLD) ? CISA_ADJ : CISA_NONE;
                    imm  = {{(XLEN-16){ext_imm[15]}}, ext_imm};
                end else begin
                    kind = CISA_ADJ;
                    imm  = {{(XLEN-11){op[7]}}, op[7:0], 3'h0};
                end
            end else if (major == OP_SP_REL_ADD) begin
                wr_addr = xlat(op[10:8]);
                if (insn_is_ext) begin
                    kind = (op[7:5] == PREFIX_ZERO_FLD) ? CISA_SPREL : CISA_NONE;
                    imm  = {{(XLEN-16){ext_imm[15]}}, ext_imm};
                end else begin
                    kind = CISA_SPREL;
                    imm  = {{(XLEN-10){1'b0}}, op[7:0], 2'h0};
                end
            end else if (!insn_is_ext && major == OP_THREE_REG && op[1:0] == FN_ADD_WORD) begin
                kind    = CISA_ADDW;
                rs_addr = xlat(op[10:8]);
                rt_addr = xlat(op[7:5]);
                wr_addr = xlat(op[4:2]);
            end else if (!insn_is_ext && major == OP_TWO_REG && op[4:0] == FN_AND) begin
                kind    = CISA_AND;
                rs_addr = xlat(op[10:8]);
                rt_addr = xlat(op[7:5]);
                wr_addr = rs_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Single-cycle results (combinational write port)
    // ------------------------------------------------------------
    // Register file latches on the edge, so no extra stage here
    always_comb begin
        wr_en   = 1'b0;
        wr_data = '0;
        case (kind)
            CISA_ADJ, CISA_SPREL: begin
                wr_en   = 1'b1;
                wr_data = sext32(rs_data + imm);
            end
            CISA_ADDW: begin
                wr_en   = 1'b1;
                wr_data = sext32(rs_data + rt_data);
            end
            CISA_AND: begin
                wr_en   = 1'b1;
                wr_data = rs_data & rt_data;
            end
            default: ;
        endcase
    end
    assign rsvd_insn = (kind == CISA_RSVD);

    // ------------------------------------------------------------
    // Macro expansion sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CISA_IDLE, CISA_FETCH, CISA_ISSUE} cisa_seq_t;
    cisa_seq_t   state, next_state;
    logic [1:0]  step, next_step;
    logic [2:0]  sel, next_sel;
    logic [25:0] prm, next_prm;
    logic [31:0] tmpl;

    cisa_macro_rom i_cisa_macro_rom (
        .clock (clock),
        .sel   (sel),
        .step  (step),
        .tmpl  (tmpl)
    );

    always_comb begin
        next_state = state;
        next_step  = step;
        next_sel   = sel;
        next_prm   = prm;
        case (state)
            CISA_IDLE: begin
                if (kind == CISA_MACRO) begin
                    next_state = CISA_FETCH;
                    next_step  = 2'h0;
                    next_sel   = insn[26:24];
                    next_prm   = {insn[23:16], op[10:0], 7'h00};
                end
            end
            CISA_FETCH: next_state = CISA_ISSUE;
            CISA_ISSUE: begin
                if (step == MACRO_STEPS - 2'h1) begin
                    next_state = CISA_IDLE;
                end else begin
                    next_step  = step + 2'h1;
                    next_state = CISA_FETCH;
                end
            end
            default: next_state = CISA_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= CISA_IDLE;
            step  <= 2'h0;
            sel   <= 3'h0;
            prm   <= '0;
        end else begin
            state <= next_state;
            step  <= next_step;
            sel   <= next_sel;
            prm   <= next_prm;
        end
    end

    // Substitute parameters; an all-zero template is a no-op and stays untouched,
    // otherwise the filled fields would turn it into a real register write
    logic [31:0] filled;
    always_comb begin
        filled = tmpl;
        if (tmpl != 32'h00000000) begin
            filled[25:21] = xlat(prm[17:15]);                // p2 -> rs
            if (tmpl[31:26] != 6'h00) begin
                filled[20:16] = xlat(prm[14:12]);            // p1 -> rt
                filled[15:0]  = {{11{prm[22]}}, prm[22:18]}; // p3 imm, signed
            end else begin
                // Logic template takes p1 translated, add template takes p4 as is
                filled[20:16] = (tmpl[5:0] == 6'h24) ? xlat(prm[14:12])
                                                     : {2'b00, prm[25:23]};
                filled[15:11] = prm[11:7];                   // p0 -> rd
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            macro_word_valid <= 1'b0;
            macro_word       <= 32'h00000000;
        end else begin
            macro_word_valid <= (state == CISA_ISSUE);
            macro_word       <= filled;
        end
    end
    // Hold PC from macro decode until last word leaves
    assign pc_hold  = (kind == CISA_MACRO && state == CISA_IDLE)
                   || state != CISA_IDLE || macro_word_valid;
    assign irq_mask = MACRO_MASKS_IRQ & pc_hold;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_adj_wraps: assert property (@(posedge clock) disable iff (rst)
        kind == CISA_ADJ |-> wr_en && wr_addr == STACK_PTR_REG
        && wr_data[XLEN-1:31] == {(XLEN-31){wr_data[31]}})
        else $error("stack adjust result not word valued");
    chk_addw_sum: assert property (@(posedge clock) disable iff (rst)
        kind == CISA_ADDW |-> wr_data[31:0] == rs_data[31:0] + rt_data[31:0])
        else $error("word add wrong");
    chk_and_dest: assert property (@(posedge clock) disable iff (rst)
        kind == CISA_AND |-> wr_addr == rs_addr && wr_data == (rs_data & rt_data))
        else $error("and wrong");
    chk_xlat_map: assert property (@(posedge clock) disable iff (rst)
        kind == CISA_ADDW && op[10:8] == 3'h1 |-> rs_addr == 5'h11)
        else $error("field translation wrong");
    chk_rsvd_nowr: assert property (@(posedge clock) disable iff (rst)
        rsvd_insn |-> !wr_en && !pc_hold)
        else $error("reserved macro had side effects");
    sequence s_macro_start;
        state == CISA_IDLE && kind == CISA_MACRO;
    endsequence
    chk_pc_held: assert property (@(posedge clock) disable iff (rst)
        s_macro_start |=> pc_hold [*5])
        else $error("pc released during macro");
    chk_macro_ends: assert property (@(posedge clock) disable iff (rst)
        s_macro_start |-> ##[1:8] state == CISA_IDLE)
        else $error("macro did not finish");
    chk_no_overflow: assert property (@(posedge clock) disable iff (rst)
        kind == CISA_SPREL |-> wr_data[31:0] == rs_data[31:0] + imm[31:0])
        else $error("stack relative sum wrong");
endmodule

//--- tb/tb_compact_isa_sp_add_logic_macro.sv
`timescale 1ns/10ps
module tb_compact_isa_sp_add_logic_macro
    import cisa_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and register file stand-in
    // ------------------------------------------------------------
    logic            clock = 1'b0;
    logic            rst = 1'b1;
    logic            insn_valid = 1'b0;
    logic            insn_is_ext = 1'b0;
    logic [31:0]     insn = 32'h0;
    logic [XLEN-1:0] rs_data, rt_data, wr_data;
    logic [4:0]      rs_addr, rt_addr, wr_addr;
    logic            wr_en, pc_hold, irq_mask, macro_word_valid, rsvd_insn;
    logic [31:0]     macro_word;
    logic [XLEN-1:0] regs [32];
    int              error_cnt = 0;
    int              n_checks = 0;

    // Combinational reads, as the register file answers in the same cycle
    assign rs_data = regs[rs_addr];
    assign rt_data = regs[rt_addr];
    always #5 clock = ~clock;

    cisa_exec i_cisa_exec (.clock(clock), .rst(rst), .insn_valid(insn_valid), .insn(insn),
        .insn_is_ext(insn_is_ext), .rs_data(rs_data), .rt_data(rt_data), .rs_addr(rs_addr),
        .rt_addr(rt_addr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .pc_hold(pc_hold), .irq_mask(irq_mask), .macro_word_valid(macro_word_valid),
        .macro_word(macro_word), .rsvd_insn(rsvd_insn));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [XLEN-1:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction

    task automatic check(input logic [XLEN-1:0] got, input logic [XLEN-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Drive one single-cycle form; outputs are combinational, so look 1 ns later
    task automatic run_single(input logic [31:0] w, input logic ext, input logic we,
                              input logic [4:0] addr, input logic [XLEN-1:0] data);
        @(negedge clock);
        insn = w;
        insn_is_ext = ext;
        insn_valid = 1'b1;
        #1;
        check(wr_en, we);
        check(rsvd_insn, 1'b0);
        if (we) begin
            check(wr_addr, addr);
            check(wr_data, data);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Short stack adjust: carry into bit 31 must wrap, never trap
    task automatic t_adj_short();
        regs[29] = sx(32'h7ffffff0);
        run_single({16'h0, 5'h0c, 3'h3, 8'h02}, 1'b0, 1'b1, 5'h1d, sx(32'h80000000));
        run_single({16'h0, 5'h0c, 3'h3, 8'hff}, 1'b0, 1'b1, 5'h1d, sx(32'h7fffffe8));
    endtask

    // Prefixed stack adjust; a nonzero field in bits 7..5 is not decoded
    task automatic t_adj_ext();
        regs[29] = sx(32'h00001000);
        run_single({5'h1e, 6'h00, 5'h10, 5'h0c, 3'h3, 3'h0, 5'h00}, 1'b1, 1'b1, 5'h1d,
                   sx(32'hffff9000));
        run_single({5'h1e, 6'h00, 5'h10, 5'h0c, 3'h3, 3'h1, 5'h00}, 1'b1, 1'b0, 5'h0,
                   64'h0);
    endtask

    // Stack-relative forms: short is zero-extended, prefixed is signed
    task automatic t_sprel();
        regs[29] = sx(32'hfffffff0);
        run_single({16'h0, 5'h00, 3'h0, 8'hff}, 1'b0, 1'b1, 5'h10, sx(32'h000003ec));
        run_single({5'h1e, 6'h3f, 5'h0f, 5'h00, 3'h7, 3'h0, 5'h1f}, 1'b1, 1'b1, 5'h07,
                   sx(32'h00007fef));
    endtask

    // Register add with wrap, then AND; fields go through translation
    task automatic t_regops();
        regs[17] = sx(32'h80000000);
        regs[2] = sx(32'h80000001);
        regs[6] = 64'hffffffff_f0f0a5a5;
        regs[16] = 64'h00000000_ff0f5a0f;
        run_single({16'h0, 5'h1c, 3'h1, 3'h2, 3'h0, 2'h1}, 1'b0, 1'b1, 5'h10, 64'h1);
        run_single({16'h0, 5'h1d, 3'h6, 3'h0, 5'h0c}, 1'b0, 1'b1, 5'h06,
                   64'h00000000_f000000_5);
        check(rs_addr, 5'h06);
        check(rt_addr, 5'h10);
    endtask

    // One macro word: hold counter, masking, words issued, or reserved trap
    task automatic t_macro(input logic [2:0] sel, input logic bad);
        int          n;
        int          i;
        int          late;
        logic [31:0] w0;
        logic [31:0] w1;
        n = 0;
        i = 0;
        late = 0;
        // Expected words of the fixed templates for p0=6 p1=1 p2=4 p3=-13 p4=2
        w0 = (sel == 3'h0) ? 32'h2491fff3 : 32'h00913024;
        w1 = (sel == 3'h0) ? 32'h00823021 : 32'h00000000;
        @(negedge clock);
        // Only defined selectors and no new word while held
        insn = {5'h1e, sel, 3'h2, 5'h13, 5'h1c, 3'h4, 3'h1, 5'h06};
        insn_is_ext = 1'b1;
        insn_valid = 1'b1;
        #1;
        check(rsvd_insn, bad);
        check(pc_hold, !bad);
        check(irq_mask, !bad);
        do begin
            @(negedge clock);
            insn_valid = 1'b0;
            if (macro_word_valid === 1'b1) begin
                check(64'((n == 0) ? w0 : w1), 64'(macro_word));
                n++;
            end
            i++;
        end while (pc_hold === 1'b1 && i < 20);
        check(64'(i == 20), 64'h0);
        if (i == 20)
            return;
        // Words arriving after the hold drops would let the counter run ahead
        repeat (3) @(negedge clock) if (macro_word_valid === 1'b1) late++;
        check(64'(late), 64'h0);
        check(64'(n), bad ? 64'h0 : 64'(MACRO_STEPS));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int r = 0; r < 32; r++)
            regs[r] = 64'h0;
        repeat (5) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        t_adj_short();
        t_adj_ext();
        t_sprel();
        t_regops();
        for (int s = 0; s < 8; s++)
            t_macro(s[2:0], !MACRO_DEFINED[s]);
        print_verdict();
    end
endmodule
